// ===== design/mie_core.sv
// Purpose: executes one slice of an 8-bit instruction set
// Assumes: one instruction offered per ready cycle, ce gates all state
// Notes: data memory and return stack live inside this module
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "mie_defs.svh"

module mie_core
	import mie_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// instruction offer
	input wire logic instrValid,
	input wire mie_op_t instrOp,
	input wire logic [7:0] instrImm,
	input wire logic [6:0] instrAddr,
	output logic instrReady,
	// register port
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	output logic [7:0] busRdata,
	// visible state
	output logic [12:0] pcOut,
	output logic [7:0] accOut,
	output logic carryOut,
	output logic halfCarryOut,
	output logic zeroOut,
	output logic overflowOut,
	output logic globalIntEnable,
	output logic skipPulse
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	mie_state_t state_q; // execute or dummy
	logic ready_q; // mirrors execute state
	logic [12:0] pc_q; // program counter
	logic [7:0] acc_q; // working accumulator
	logic carry_q; // carry flag
	logic half_q; // half carry flag
	logic zero_q; // zero flag
	logic ovf_q; // overflow flag
	logic gie_q; // global interrupt enable
	logic skip_q; // dummy cycle is a skip
	logic [7:0] rdata_q; // read data, one cycle late
	logic [7:0] mem_q [128]; // data memory, not reset
	logic [12:0] stack_q [16]; // return stack
	logic [3:0] sp_q; // next free stack slot
	logic [4:0] stkHi_q; // staged upper bits of a push

	// ----------------------------------------
	// datapath wires
	// ----------------------------------------
	logic issue; // instruction taken this cycle
	logic [7:0] opnd; // addressed memory byte
	logic [7:0] accD; // next accumulator
	logic memWe; // memory write by instruction
	logic [7:0] memD; // memory write data
	logic carryD;
	logic halfD;
	logic zeroD;
	logic ovfD;
	logic gieD;
	logic retD; // pop the stack
	logic skipD; // discard next instruction
	logic [8:0] sbcSum; // full subtract sum
	logic [4:0] sbcLow; // low nibble sum
	logic [7:0] orV; // or result
	logic [7:0] decV; // decremented byte
	logic [3:0] spTop; // slot of the top entry
	logic busIdle; // bus may touch core state

	assign issue = ce && instrValid && ready_q;
	assign spTop = sp_q - 4'h1;
	// instruction wins over a bus write in the same cycle
	assign busIdle = ce && !issue;

	// ----------------------------------------
	// execute decode
	// ----------------------------------------
	// one table: result, destination, flags
	always_comb begin
		opnd = mem_q[instrAddr];
		accD = acc_q;
		memWe = 1'b0;
		memD = opnd;
		carryD = carry_q;
		halfD = half_q;
		zeroD = zero_q;
		ovfD = ovf_q;
		gieD = gie_q;
		retD = 1'b0;
		skipD = 1'b0;
		orV = acc_q | opnd;
		decV = opnd - 8'h01;
		// borrow form: a plus inverted m plus carry
		sbcSum = {1'b0, acc_q} + {1'b0, ~opnd} + {8'h00, carry_q};
		sbcLow = {1'b0, acc_q[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, carry_q};
		unique case (instrOp)
			OP_NOP: begin
				accD = acc_q;
			end
			OP_MOV_A_M: begin
				accD = opnd;
			end
			OP_MOV_A_X: begin
				accD = instrImm;
			end
			OP_MOV_M_A: begin
				memWe = 1'b1;
				memD = acc_q;
			end
			OP_OR_A_M: begin
				accD = orV;
				zeroD = (orV == 8'h00);
			end
			OP_OR_A_X: begin
				accD = acc_q | instrImm;
				zeroD = ((acc_q | instrImm) == 8'h00);
			end
			OP_OR_TO_MEM: begin
				memWe = 1'b1;
				memD = orV;
				zeroD = (orV == 8'h00);
			end
			OP_RET: begin
				retD = 1'b1;
			end
			OP_RET_A_X: begin
				retD = 1'b1;
				accD = instrImm;
			end
			OP_INT_RETURN: begin
				retD = 1'b1;
				gieD = 1'b1;
			end
			OP_RL: begin
				memWe = 1'b1;
				memD = {opnd[6:0], opnd[7]};
			end
			OP_RLA: begin
				accD = {opnd[6:0], opnd[7]};
			end
			OP_RLC: begin
				memWe = 1'b1;
				memD = {opnd[6:0], carry_q};
				carryD = opnd[7];
			end
			OP_RLCA: begin
				accD = {opnd[6:0], carry_q};
				carryD = opnd[7];
			end
			OP_RR: begin
				memWe = 1'b1;
				memD = {opnd[0], opnd[7:1]};
			end
			OP_RRA: begin
				accD = {opnd[0], opnd[7:1]};
			end
			OP_RRC: begin
				memWe = 1'b1;
				memD = {carry_q, opnd[7:1]};
				carryD = opnd[0];
			end
			OP_RRCA: begin
				accD = {carry_q, opnd[7:1]};
				carryD = opnd[0];
			end
			OP_SBC, OP_SBC_TO_MEM: begin
				if (instrOp == OP_SBC) begin
					accD = sbcSum[7:0];
				end else begin
					memWe = 1'b1;
					memD = sbcSum[7:0];
				end
				carryD = sbcSum[8];
				halfD = sbcLow[4];
				zeroD = (sbcSum[7:0] == 8'h00);
				// signs equal in, sign differs out
				ovfD = (acc_q[7] == ~opnd[7]) && (sbcSum[7] != acc_q[7]);
			end
			OP_DEC_SKIP: begin
				memWe = 1'b1;
				memD = decV;
				skipD = (decV == 8'h00);
			end
			OP_DEC_ACC_SKIP: begin
				accD = decV;
				skipD = (decV == 8'h00);
			end
			default: begin
				accD = acc_q; // illegal code acts as no-operation
			end
		endcase
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	// returns and taken skips spend one dummy cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_EXEC;
			ready_q <= 1'b1;
		end else if (ce) begin
			if (issue && (retD || skipD)) begin
				state_q <= ST_DUMMY;
				ready_q <= 1'b0;
			end else begin
				state_q <= ST_EXEC;
				ready_q <= 1'b1;
			end
		end
	end

	// marks the dummy cycle of a taken skip
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			skip_q <= 1'b0;
		end else if (ce) begin
			skip_q <= issue && skipD;
		end
	end

	// program counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q <= `MIE_PC_RST;
		end else if (issue) begin
			// pop on return, else next word
			pc_q <= retD ? stack_q[spTop] : pc_q + 13'h0001;
		end else if (ce && skip_q) begin
			pc_q <= pc_q + 13'h0001; // discarded word passed over
		end
	end

	// ----------------------------------------
	// accumulator and flags
	// ----------------------------------------
	// bus writes only land when no instruction issues
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= `MIE_ACC_RST;
		end else if (issue) begin
			acc_q <= accD;
		end else if (busIdle && busWr && busAddr == `MIE_REG_ACC) begin
			acc_q <= busWdata;
		end
	end

	// flags follow the decode table
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			carry_q <= 1'b0;
			half_q <= 1'b0;
			zero_q <= 1'b0;
			ovf_q <= 1'b0;
			gie_q <= 1'b0;
		end else if (issue) begin
			carry_q <= carryD;
			half_q <= halfD;
			zero_q <= zeroD;
			ovf_q <= ovfD;
			gie_q <= gieD;
		end else if (busIdle && busWr && busAddr == `MIE_REG_STATUS) begin
			carry_q <= busWdata[`MIE_ST_CARRY];
			half_q <= busWdata[`MIE_ST_HALF];
			zero_q <= busWdata[`MIE_ST_ZERO];
			ovf_q <= busWdata[`MIE_ST_OVF];
			gie_q <= busWdata[`MIE_ST_GIE];
		end
	end

	// ----------------------------------------
	// data memory
	// ----------------------------------------
	// plain array, contents undefined after reset
	always_ff @(posedge clk) begin
		if (issue && memWe) begin
			mem_q[instrAddr] <= memD;
		end else if (busIdle && busWr && busAddr[`MIE_MEM_SEL_BIT]) begin
			mem_q[busAddr[6:0]] <= busWdata;
		end
	end

	// ----------------------------------------
	// return stack
	// ----------------------------------------
	// entries written only by the bus push
	always_ff @(posedge clk) begin
		if (busIdle && busWr && busAddr == `MIE_REG_STK_PUSH) begin
			stack_q[sp_q] <= {stkHi_q, busWdata};
		end
	end

	// pointer wraps; an empty pop reads a stale slot
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sp_q <= `MIE_SP_RST;
		end else if (issue && retD) begin
			sp_q <= spTop;
		end else if (busIdle && busWr && busAddr == `MIE_REG_STK_PUSH) begin
			sp_q <= sp_q + 4'h1;
		end
	end

	// upper bits staged before a push
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stkHi_q <= 5'h00;
		end else if (ce && busWr && busAddr == `MIE_REG_STK_HI) begin
			stkHi_q <= busWdata[4:0];
		end
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	// data stand one cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			if (!busRd) begin
				rdata_q <= 8'h00;
			end else if (busAddr[`MIE_MEM_SEL_BIT]) begin
				rdata_q <= mem_q[busAddr[6:0]];
			end else begin
				unique case (busAddr)
					`MIE_REG_ACC: rdata_q <= acc_q;
					`MIE_REG_STATUS: begin
						rdata_q <= {3'h0, gie_q, ovf_q, zero_q, half_q, carry_q};
					end
					`MIE_REG_PC_LO: rdata_q <= pc_q[7:0];
					`MIE_REG_PC_HI: rdata_q <= {3'h0, pc_q[12:8]};
					`MIE_REG_STK_PUSH: rdata_q <= {4'h0, sp_q};
					`MIE_REG_STK_HI: rdata_q <= {3'h0, stkHi_q};
					// unmapped reads return zero
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign instrReady = ready_q;
	assign busRdata = rdata_q;
	assign pcOut = pc_q;
	assign accOut = acc_q;
	assign carryOut = carry_q;
	assign halfCarryOut = half_q;
	assign zeroOut = zero_q;
	assign overflowOut = ovf_q;
	assign globalIntEnable = gie_q;
	assign skipPulse = skip_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_mov_load: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_MOV_A_M |=> acc_q == $past(opnd)
			&& $stable({carry_q, half_q, zero_q, ovf_q}))
	else $error("memory move lost data or touched flags");

	chk_imm_load: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_MOV_A_X |=> acc_q == $past(instrImm))
	else $error("immediate move wrong");

	chk_store_mem: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_MOV_M_A
			|=> mem_q[$past(instrAddr)] == $past(acc_q))
	else $error("store did not reach memory");

	chk_nop_pc: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_NOP
			|=> pc_q == $past(pc_q) + 13'h0001 && $stable(acc_q))
	else $error("no-operation changed state");

	chk_or_zero: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_OR_A_X
			|=> zero_q == (acc_q == 8'h00) && $stable(carry_q))
	else $error("or zero flag wrong");

	chk_ret_long: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_RET |=> !ready_q && state_q == ST_DUMMY)
	else $error("return not two cycles");

	chk_interrupt_return_gie: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_INT_RETURN |=> gie_q)
	else $error("interrupt return left enable clear");

	chk_rlc_carry: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_RLCA
			|=> carry_q == $past(opnd[7]) && acc_q[0] == $past(carry_q))
	else $error("rotate through carry wrong");

	chk_sbc_sum: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_SBC
			|=> acc_q == $past(sbcSum[7:0]) && carry_q == $past(sbcSum[8]))
	else $error("subtract with borrow wrong");

	chk_skip_time: assert property (
		@(posedge clk) disable iff (!reset_n)
		issue && instrOp == OP_DEC_SKIP && opnd == 8'h01
			|=> skip_q && !ready_q ##1 !skip_q)
	else $error("taken skip timing wrong");

endmodule

// ===== inc/mie_defs.svh
// Purpose: constants of the instruction execution slice
// Assumes: one clock at 100 MHz, registers on a plain strobe port
// Notes: offsets, field positions, reset values and cycle counts
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MIE_REG_ACC 8'h00
`define MIE_REG_STATUS 8'h01
`define MIE_REG_PC_LO 8'h02
`define MIE_REG_PC_HI 8'h03
`define MIE_REG_STK_PUSH 8'h04
`define MIE_REG_STK_HI 8'h05
`define MIE_MEM_SEL_BIT 7

// ----------------------------------------
// status field positions
// ----------------------------------------
`define MIE_ST_CARRY 0
`define MIE_ST_HALF 1
`define MIE_ST_ZERO 2
`define MIE_ST_OVF 3
`define MIE_ST_GIE 4

// ----------------------------------------
// reset values and cycle counts
// ----------------------------------------
`define MIE_ACC_RST 8'h00
`define MIE_PC_RST 13'h0000
`define MIE_SP_RST 4'h0
`define MIE_CYC_LONG 2
`define MIE_CYC_SHORT 1

`endif

// ===== inc/mie_pkg.sv
// Purpose: types of the instruction execution slice
// Assumes: included after mie_defs.svh where needed
// Notes: opcode codes are local to this core
package mie_pkg;

	// instruction selector
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_MOV_A_M = 5'h01,
		OP_MOV_A_X = 5'h02,
		OP_MOV_M_A = 5'h03,
		OP_OR_A_M = 5'h04,
		OP_OR_A_X = 5'h05,
		OP_OR_TO_MEM = 5'h06,
		OP_RET = 5'h07,
		OP_RET_A_X = 5'h08,
		OP_INT_RETURN = 5'h09,
		OP_RL = 5'h0A,
		OP_RLA = 5'h0B,
		OP_RLC = 5'h0C,
		OP_RLCA = 5'h0D,
		OP_RR = 5'h0E,
		OP_RRA = 5'h0F,
		OP_RRC = 5'h10,
		OP_RRCA = 5'h11,
		OP_SBC = 5'h12,
		OP_SBC_TO_MEM = 5'h13,
		OP_DEC_SKIP = 5'h14,
		OP_DEC_ACC_SKIP = 5'h15
	} mie_op_t;

	// execution state, one bit gray
	typedef enum logic {
		ST_EXEC = 1'b0,
		ST_DUMMY = 1'b1
	} mie_state_t;

endpackage

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the execution slice
// Assumes: bench drives every port itself, one 100 MHz clock
// Notes: driver queues expected results, monitors pop and compare
`timescale 1ns/1ps
module tb_top
	import mie_pkg::*;
();
	// ----------------------------------------
	// ports and model state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] acc;
		logic [4:0] st;
		logic [12:0] pc;
		logic rdy;
		logic skp;
	} mie_exp_t;
	logic clk, reset_n, ce, instrValid, instrReady, busWr, busRd, skipPulse;
	logic carryOut, halfCarryOut, zeroOut, overflowOut, globalIntEnable;
	mie_op_t instrOp;
	logic [7:0] instrImm, busAddr, busWdata, busRdata, accOut;
	logic [6:0] instrAddr, a;
	logic [12:0] pcOut;
	logic [4:0] stSeen; // flags as seen: gie, ovf, zero, half, carry
	mie_exp_t expQ[$]; // instruction results in issue order
	logic [7:0] rdQ[$]; // read data in issue order
	logic [12:0] stkQ[$]; // mirror of pushed return addresses
	logic [7:0] mMem [0:127];
	logic [7:0] mAcc, stkHi;
	logic [4:0] mSt; // gie, ovf, zero, half, carry
	logic [12:0] mPc;
	logic [31:0] seed = 32'h0000F5F7;
	logic [31:0] t;
	int n_errors, checks_done, i, j, k;

	mie_core mie_core_i (.clk(clk), .reset_n(reset_n), .ce(ce), .instrValid(instrValid),
		.instrOp(instrOp), .instrImm(instrImm), .instrAddr(instrAddr),
		.instrReady(instrReady), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
		.busRd(busRd), .busRdata(busRdata), .pcOut(pcOut), .accOut(accOut),
		.carryOut(carryOut), .halfCarryOut(halfCarryOut), .zeroOut(zeroOut),
		.overflowOut(overflowOut), .globalIntEnable(globalIntEnable), .skipPulse(skipPulse));
	assign stSeen = {globalIntEnable, overflowOut, zeroOut, halfCarryOut, carryOut};

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// xorshift, fixed start so runs repeat
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task print_verdict();
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// every instruction and bus input set once per edge (ce and reset_n are not), so no strobe is assigned twice
	task drive(input logic v, input mie_op_t op, input logic [7:0] x, input logic [6:0] ad,
		input logic wr, input logic rd, input logic [7:0] ba, input logic [7:0] bd);
		instrValid <= v;
		instrOp <= op;
		instrImm <= x;
		instrAddr <= ad;
		busWr <= wr;
		busRd <= rd;
		busAddr <= ba;
		busWdata <= bd;
		@(posedge clk);
	endtask

	task busW(input logic [7:0] ba, input logic [7:0] d);
		if (ba[7]) mMem[ba[6:0]] = d;
		else if (ba == 8'h00) mAcc = d;
		else if (ba == 8'h01) mSt = d[4:0];
		else if (ba == 8'h05) stkHi = d;
		else if (ba == 8'h04) stkQ.push_back({stkHi[4:0], d});
		drive(1'b0, OP_NOP, 8'h00, 7'h00, 1'b1, 1'b0, ba, d);
	endtask

	task busR(input logic [7:0] ba, input logic [7:0] exp);
		rdQ.push_back(exp);
		drive(1'b0, OP_NOP, 8'h00, 7'h00, 1'b0, 1'b1, ba, 8'h00);
	endtask

	// ----------------------------------------
	// reference model of one instruction
	// ----------------------------------------
	task model(input mie_op_t op, input logic [7:0] x, input logic [6:0] ad, output logic lng);
		logic [7:0] m, r;
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] l7; // carry into the sign bit, for overflow
		logic c, skp;
		m = mMem[ad];
		c = mSt[0];
		r = 8'h00;
		lng = 1'b0;
		skp = 1'b0;
		mPc = mPc + 13'h0001;
		case (op)
			OP_MOV_A_M: mAcc = m;
			OP_MOV_A_X: mAcc = x;
			OP_MOV_M_A: mMem[ad] = mAcc;
			OP_OR_A_M, OP_OR_A_X, OP_OR_TO_MEM: begin
				r = mAcc | ((op == OP_OR_A_X) ? x : m);
				mSt[2] = (r == 8'h00);
			end
			OP_RET, OP_RET_A_X, OP_INT_RETURN: begin
				mPc = stkQ.pop_back();
				lng = 1'b1;
				if (op == OP_RET_A_X) mAcc = x;
				if (op == OP_INT_RETURN) mSt[4] = 1'b1;
			end
			OP_RL, OP_RLA: r = {m[6:0], m[7]};
			OP_RLC, OP_RLCA: begin
				r = {m[6:0], c};
				mSt[0] = m[7];
			end
			OP_RR, OP_RRA: r = {m[0], m[7:1]};
			OP_RRC, OP_RRCA: begin
				r = {c, m[7:1]};
				mSt[0] = m[0];
			end
			OP_SBC, OP_SBC_TO_MEM: begin
				s = {1'b0, mAcc} + {1'b0, ~m} + {8'h00, c};
				h = {1'b0, mAcc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
				r = s[7:0];
				// overflow: carry into bit 7 differs from carry out of bit 7
				l7 = {1'b0, mAcc[6:0]} + {1'b0, ~m[6:0]} + {7'h00, c};
				mSt[3:0] = {l7[7] ^ s[8], r == 8'h00, h[4], s[8]};
			end
			OP_DEC_SKIP, OP_DEC_ACC_SKIP: begin
				r = m - 8'h01;
				skp = (r == 8'h00);
				lng = skp;
			end
			default: ;
		endcase
		if (op inside {OP_OR_TO_MEM, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SBC_TO_MEM, OP_DEC_SKIP})
			mMem[ad] = r;
		if (op inside {OP_OR_A_M, OP_OR_A_X, OP_RLA, OP_RLCA, OP_RRA, OP_RRCA, OP_SBC,
			OP_DEC_ACC_SKIP}) mAcc = r;
		expQ.push_back({mAcc, mSt, mPc, ~lng, skp});
		if (skp) mPc = mPc + 13'h0001; // dummy cycle advances again
	endtask

	// offer held one more edge after a long one, so the core must refuse it
	task issue(input mie_op_t op, input logic [7:0] x, input logic [6:0] ad);
		logic lng;
		model(op, x, ad, lng);
		drive(1'b1, op, x, ad, 1'b0, 1'b0, 8'h00, 8'h00);
		if (lng) @(posedge clk);
	endtask

	// ----------------------------------------
	// monitors
	// ----------------------------------------
	always @(posedge clk) begin
		if (reset_n && ce && instrValid && instrReady) begin
			#1;
			if (expQ.size() == 0) check(16'h0000, 16'h0001);
			else begin
				check({3'h0, pcOut}, {3'h0, expQ[0].pc});
				check({8'h00, accOut}, {8'h00, expQ[0].acc});
				check(16'(stSeen), 16'(expQ[0].st));
				check({14'h0000, instrReady, skipPulse},
					{14'h0000, expQ[0].rdy, expQ[0].skp});
				void'(expQ.pop_front());
			end
		end
	end

	always @(posedge clk) begin
		if (reset_n && ce && busRd) begin
			#1;
			check({8'h00, busRdata}, {8'h00, rdQ.pop_front()});
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		instrValid = 1'b0;
		instrOp = OP_NOP;
		instrImm = 8'h00;
		instrAddr = 7'h00;
		busAddr = 8'h00;
		busWdata = 8'h00;
		busWr = 1'b0;
		busRd = 1'b0;
		mAcc = 8'h00;
		mSt = 5'h00;
		mPc = 13'h0000;
		stkHi = 8'h00;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		check({3'h0, pcOut}, 16'h0000);
		check({accOut, busRdata}, 16'h0000);
		check({9'h000, instrReady, skipPulse, stSeen}, 16'h0040);
		@(posedge clk);
		// random contents for the bytes in use
		for (i = 0; i < 16; i++) begin
			t = rnd();
			busW({1'b1, i[6:0]}, t[7:0]);
		end
		// every code; last round forces a zero decrement
		for (k = 0; k < 4; k++) begin
			for (j = 0; j < 22; j++) begin
				t = rnd();
				a = {3'h0, t[3:0]};
				if (k == 3) busW({1'b1, a}, 8'h01);
				busW(8'h01, {4'h0, t[11:8]});
				if (j inside {7, 8, 9}) begin
					busW(8'h05, t[15:8]);
					busW(8'h04, t[23:16]);
				end
				issue(mie_op_t'(j[4:0]), t[31:24], a);
				busR({1'b1, a}, mMem[a]);
			end
		end
		// back to back, skip then no skip, then a zero result
		busW(8'h85, 8'h01);
		issue(OP_DEC_SKIP, 8'h00, 7'h05);
		issue(OP_DEC_ACC_SKIP, 8'h00, 7'h05);
		issue(OP_MOV_A_X, 8'h00, 7'h00);
		issue(OP_OR_A_X, 8'h00, 7'h00);
		issue(OP_NOP, 8'h00, 7'h00);
		// an unused code must behave as a no-operation
		issue(mie_op_t'(5'h16), 8'h5A, 7'h01);
		// clock enable low: offer and bus write are both dropped, state frozen
		ce <= 1'b0;
		drive(1'b1, OP_MOV_A_X, 8'h77, 7'h00, 1'b1, 1'b0, 8'h00, 8'h77);
		drive(1'b0, OP_NOP, 8'h00, 7'h00, 1'b0, 1'b0, 8'h00, 8'h00);
		ce <= 1'b1;
		// register port, unmapped place first
		busW(8'h06, 8'hA5);
		busR(8'h06, 8'h00);
		busR(8'h00, mAcc);
		busR(8'h01, {3'h0, mSt});
		busR(8'h02, mPc[7:0]);
		busR(8'h03, {3'h0, mPc[12:8]});
		busR(8'h04, 8'(stkQ.size()));
		busR(8'h05, {3'h0, stkHi[4:0]});
		drive(1'b0, OP_NOP, 8'h00, 7'h00, 1'b0, 1'b0, 8'h00, 8'h00);
		repeat (2) @(posedge clk);
		check(16'(expQ.size() + rdQ.size()), 16'h0000);
		print_verdict();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
endmodule
